// ### rtl/bcs_pkg.sv
package bcs_pkg;
	// Data widths for measurements and targets
	localparam int BCS_DW = 16;
	// Clock and qualification timing
	localparam longint BCS_CLK_HZ = 10000000;
	localparam longint BCS_TERM_TIME_S = 40;
	localparam longint BCS_TERM_CYCLES = BCS_TERM_TIME_S * BCS_CLK_HZ;
	localparam int BCS_TMR_W = 32;
	// Register map
	localparam logic [11:0] BCS_CTRL_OFF = 12'h000;
	localparam logic [11:0] BCS_STAT_OFF = 12'h004;
	localparam logic [11:0] BCS_VCHG_OFF = 12'h008;
	localparam logic [11:0] BCS_ICHG_OFF = 12'h00c;
	localparam logic [11:0] BCS_IMAX_OFF = 12'h010;
	localparam logic [11:0] BCS_IPRE_OFF = 12'h014;
	localparam logic [11:0] BCS_VPRE_OFF = 12'h018;
	localparam logic [11:0] BCS_VLIM_OFF = 12'h01c;
	localparam logic [11:0] BCS_VTLO_OFF = 12'h020;
	localparam logic [11:0] BCS_ITAP_OFF = 12'h024;
	localparam logic [11:0] BCS_TADJ_OFF = 12'h028;
	// Control register fields
	localparam int BCS_CTRL_EN = 0;
	localparam int BCS_CTRL_EXTPRE = 1;
	localparam int BCS_CTRL_ZV = 2;
	localparam int BCS_CTRL_CHGON = 3;
	localparam int BCS_CTRL_DSGEN = 4;
	localparam int BCS_CTRL_RESTART = 5;
	localparam logic [31:0] BCS_CTRL_RST = 32'h0000_0010;
	// Status register fields
	localparam int BCS_ST_TERM = 8;
	localparam int BCS_ST_TERMFLG = 9;
	localparam int BCS_ST_FAULT = 10;
	localparam int BCS_ST_CVLIM = 11;
	localparam int BCS_ST_CCLIM = 12;
	// Target reset values
	localparam logic [15:0] BCS_TGT_RST = 16'h0000;
	// Charge phase encoding
	typedef enum logic [2:0] {
		BCS_IDLE = 3'b000,
		BCS_PRE = 3'b001,
		BCS_CC = 3'b010,
		BCS_CV = 3'b011,
		BCS_DONE = 3'b100
	} bcs_phase_t;
endpackage

// ### rtl/bcs_sync.sv
`timescale 1ns/1ps
module bcs_sync
	import bcs_pkg::*;
#(
	parameter int W = 1
)(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Async in, sync out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// Two stages; the first is read only by the second
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_r <= '0;
			q <= '0;
		end
		else
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // bcs_sync

// ### rtl/bcs_term_timer.sv
`timescale 1ns/1ps
module bcs_term_timer
	import bcs_pkg::*;
#(
	parameter longint TERM_CYCLES = BCS_TERM_CYCLES
)(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Qualification inputs
	input wire logic arm,
	input wire logic cond,
	// Result
	output logic done
);
	localparam logic [BCS_TMR_W-1:0] LAST = BCS_TMR_W'(TERM_CYCLES - 1);
	logic [BCS_TMR_W-1:0] cnt_r;

	// Restart from zero whenever either condition drops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_r <= '0;
			done <= 1'b0;
		end
		else if (!arm || !cond)
		begin
			cnt_r <= '0; // R15
			done <= 1'b0;
		end
		else if (cnt_r >= LAST)
			done <= 1'b1; // R10
		else
			cnt_r <= cnt_r + 1'b1;
	end
endmodule // bcs_term_timer

// ### rtl/bcs_sequencer.sv
`timescale 1ns/1ps
// Overview of operation
// (R1) Start target from minimum cell voltage
// (R2) CC loads adjusted target, regulates inductor current
// (R3) At voltage target hold voltage, let taper
// (R4) Cap delivered current at charge request
// (R5) After termination raise limit to maximum
// (R6) Precharge and CV use stack-bottom sense
// (R7) Cycle-by-cycle limit from inductor sense
// (R8) Zero-volt mode: narrow-voltage output drives charge gate
// (R9) Max cell at limit stops voltage increase
// (R10) Window and taper for 40 s terminates
// (R11) Internal or external precharge selectable
// (R12) System may turn charge switch on
// (R13) Safety fault forces both switches off
// (R14) Host may override voltage, current targets
// (R15) Qualification timer restarts on any dropout
module bcs_sequencer
	import bcs_pkg::*;
#(
	parameter longint TERM_CYCLES = BCS_TERM_CYCLES
)(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Measurements from the gauge
	input wire logic [15:0] min_cell_mv,
	input wire logic [15:0] max_cell_mv,
	input wire logic [15:0] pack_mv,
	input wire logic [15:0] meas_ma,
	// Pins from the power stage
	input wire logic safety_fault,
	input wire logic ind_oc_trip,
	// Power stage control
	output logic [15:0] v_target,
	output logic [15:0] i_target,
	output logic [15:0] i_limit,
	output logic sense_sel_bottom,
	output logic cycle_kill,
	output logic buck_en,
	output logic ext_pre_sw,
	// Switch drives
	output logic charge_switch_gate,
	output logic discharge_switch_gate,
	output logic narrow_voltage_dc_output
);
	logic [31:0] ctrl_r;
	logic [15:0] vchg_r, ichg_r, imax_r, ipre_r, vpre_r, vlim_r, vtlo_r, itap_r, tadj_r;
	logic fault_s, oc_s;
	bcs_phase_t phase_r, phase_nxt;
	logic term_flag_r, term_done;
	logic [31:0] rd_nxt;
	logic wr_en, rd_en, map_hit;
	logic [15:0] adj_i, i_nxt;
	logic run_en_w, ext_pre_w, zero_v_w, gate_force_w, dis_gate_en_w, restart_w;
	logic taper_ok, narrow_voltage_dc_output_nxt;
	logic [31:0] stat_w;

	function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
		sat_sub = (a > b) ? (a - b) : 16'h0000;
	endfunction

	function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
		min16 = (a < b) ? a : b;
	endfunction

	function automatic logic in_window(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		in_window = (v >= lo) && (v <= hi);
	endfunction

	// Pins from outside the clock domain
	bcs_sync #(.W(2)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({safety_fault, ind_oc_trip}),
		.q({fault_s, oc_s})
	);

	// Control fields by name, so the decode below reads as the rules do
	assign run_en_w = ctrl_r[BCS_CTRL_EN];
	assign ext_pre_w = ctrl_r[BCS_CTRL_EXTPRE];
	assign zero_v_w = ctrl_r[BCS_CTRL_ZV];
	assign gate_force_w = ctrl_r[BCS_CTRL_CHGON];
	assign dis_gate_en_w = ctrl_r[BCS_CTRL_DSGEN];
	assign restart_w = ctrl_r[BCS_CTRL_RESTART];

	// Window and taper must hold together; either dropping restarts the count
	assign taper_ok = in_window(max_cell_mv, vtlo_r, vlim_r) && (meas_ma < itap_r); // R10

	// Termination qualification timer
	bcs_term_timer #(.TERM_CYCLES(TERM_CYCLES)) u_tmr (
		.pclk(pclk),
		.presetn(presetn),
		.arm(phase_r == BCS_CV),
		.cond(taper_ok),
		.done(term_done)
	);

	// Bus decode; single-cycle access
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	always_comb
	begin
		map_hit = 1'b1;
		case (paddr)
			BCS_CTRL_OFF, BCS_STAT_OFF, BCS_VCHG_OFF, BCS_ICHG_OFF, BCS_IMAX_OFF,
			BCS_IPRE_OFF, BCS_VPRE_OFF, BCS_VLIM_OFF, BCS_VTLO_OFF, BCS_ITAP_OFF,
			BCS_TADJ_OFF: map_hit = 1'b1;
			default: map_hit = 1'b0;
		endcase
	end

	// Writable registers; restart bit is self-clearing
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r <= BCS_CTRL_RST;
			vchg_r <= BCS_TGT_RST;
			ichg_r <= BCS_TGT_RST;
			imax_r <= BCS_TGT_RST;
			ipre_r <= BCS_TGT_RST;
			vpre_r <= BCS_TGT_RST;
			vlim_r <= BCS_TGT_RST;
			vtlo_r <= BCS_TGT_RST;
			itap_r <= BCS_TGT_RST;
			tadj_r <= BCS_TGT_RST;
		end
		else
		begin
			ctrl_r[BCS_CTRL_RESTART] <= 1'b0;
			if (wr_en)
			begin
				case (paddr)
					BCS_CTRL_OFF: ctrl_r <= pwdata;
					BCS_VCHG_OFF: vchg_r <= pwdata[15:0]; // R14
					BCS_ICHG_OFF: ichg_r <= pwdata[15:0]; // R14
					BCS_IMAX_OFF: imax_r <= pwdata[15:0];
					BCS_IPRE_OFF: ipre_r <= pwdata[15:0];
					BCS_VPRE_OFF: vpre_r <= pwdata[15:0];
					BCS_VLIM_OFF: vlim_r <= pwdata[15:0];
					BCS_VTLO_OFF: vtlo_r <= pwdata[15:0];
					BCS_ITAP_OFF: itap_r <= pwdata[15:0];
					BCS_TADJ_OFF: tadj_r <= pwdata[15:0];
					default: ;
				endcase
			end
		end
	end

	// Status word built field by field; unused bits read as zero
	always_comb
	begin
		stat_w = 32'h0000_0000;
		stat_w[$bits(bcs_phase_t)-1:0] = phase_r;
		stat_w[BCS_ST_TERM] = (phase_r == BCS_DONE);
		stat_w[BCS_ST_TERMFLG] = term_flag_r;
		stat_w[BCS_ST_FAULT] = fault_s;
		stat_w[BCS_ST_CVLIM] = (phase_r == BCS_CV);
		stat_w[BCS_ST_CCLIM] = oc_s;
	end

	// Read mux
	always_comb
	begin
		case (paddr)
			BCS_CTRL_OFF: rd_nxt = ctrl_r;
			BCS_STAT_OFF: rd_nxt = stat_w;
			BCS_VCHG_OFF: rd_nxt = {16'h0, vchg_r};
			BCS_ICHG_OFF: rd_nxt = {16'h0, ichg_r};
			BCS_IMAX_OFF: rd_nxt = {16'h0, imax_r};
			BCS_IPRE_OFF: rd_nxt = {16'h0, ipre_r};
			BCS_VPRE_OFF: rd_nxt = {16'h0, vpre_r};
			BCS_VLIM_OFF: rd_nxt = {16'h0, vlim_r};
			BCS_VTLO_OFF: rd_nxt = {16'h0, vtlo_r};
			BCS_ITAP_OFF: rd_nxt = {16'h0, itap_r};
			BCS_TADJ_OFF: rd_nxt = {16'h0, tadj_r};
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	// Read data latched in setup; answer has no wait states
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			if (rd_en)
				prdata <= rd_nxt;
			pready <= psel && !penable;
			pslverr <= psel && !penable && !map_hit;
		end
	end

	// Phase sequencing
	always_comb
	begin
		phase_nxt = phase_r;
		case (phase_r)
			BCS_IDLE:
				if (run_en_w)
					phase_nxt = (min_cell_mv < vpre_r) ? BCS_PRE : BCS_CC; // R1
			BCS_PRE:
				if (min_cell_mv >= vpre_r)
					phase_nxt = BCS_CC;
			BCS_CC:
				if (max_cell_mv >= vlim_r || pack_mv >= vchg_r)
					phase_nxt = BCS_CV; // R3 R9
			BCS_CV:
				if (term_done)
					phase_nxt = BCS_DONE; // R10
			BCS_DONE:
				if (restart_w)
					phase_nxt = BCS_IDLE;
			default: phase_nxt = BCS_IDLE;
		endcase
		// A fault drops to idle, but a finished charge stays finished while enabled
		if (!run_en_w || fault_s)
			phase_nxt = (phase_r == BCS_DONE && run_en_w) ? BCS_DONE : BCS_IDLE;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase_r <= BCS_IDLE;
		else
			phase_r <= phase_nxt;
	end

	// Termination flag: set wins over restart
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			term_flag_r <= 1'b0;
		else if (phase_r == BCS_CV && term_done)
			term_flag_r <= 1'b1; // R10
		else if (restart_w)
			term_flag_r <= 1'b0;
	end

	// Current target: max-cell derating in CC and CV
	assign adj_i = sat_sub(ichg_r, (max_cell_mv >= vtlo_r) ? tadj_r : 16'h0000);
	always_comb
	begin
		case (phase_nxt)
			BCS_PRE: i_nxt = min16(ipre_r, ichg_r); // R1 R4
			BCS_CC, BCS_CV: i_nxt = min16(adj_i, ichg_r); // R2 R4
			default: i_nxt = 16'h0000;
		endcase
	end

	// Outside idle the voltage target may fall but never rise once the highest cell is at its limit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			v_target <= BCS_TGT_RST;
		else if (phase_nxt != BCS_IDLE && max_cell_mv >= vlim_r)
			v_target <= min16(v_target, vchg_r); // R3 R9
		else
			v_target <= vchg_r; // R2 R14
	end

	// Current target follows the phase the sequencer is entering
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			i_target <= BCS_TGT_RST;
		else
			i_target <= i_nxt; // R2
	end

	// Only after termination is the load given the full current
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			i_limit <= BCS_TGT_RST;
		else
			i_limit <= (phase_nxt == BCS_DONE) ? imax_r : ichg_r; // R4 R5
	end

	// Average current is sensed at the stack bottom in precharge and CV
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sense_sel_bottom <= 1'b0;
		else
			sense_sel_bottom <= (phase_nxt == BCS_PRE) || (phase_nxt == BCS_CV); // R6
	end

	// External precharge bypasses the buck; a fault stops both paths
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			buck_en <= 1'b0;
			ext_pre_sw <= 1'b0;
		end
		else
		begin
			buck_en <= (phase_nxt != BCS_IDLE) && !fault_s &&
				!(phase_nxt == BCS_PRE && ext_pre_w); // R11
			ext_pre_sw <= (phase_nxt == BCS_PRE) && ext_pre_w && !fault_s; // R11
		end
	end

	// Per-cycle limit: trip ends the current switching cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cycle_kill <= 1'b0;
		else
			cycle_kill <= oc_s && buck_en; // R7
	end

	// In zero-volt precharge the charge gate is driven from the narrow-voltage output
	assign narrow_voltage_dc_output_nxt = (phase_nxt == BCS_PRE) && zero_v_w; // R8

	// Switch gates; fault overrides everything
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			charge_switch_gate <= 1'b0;
			discharge_switch_gate <= 1'b0;
			narrow_voltage_dc_output <= 1'b0;
		end
		else if (fault_s)
		begin
			charge_switch_gate <= 1'b0; // R13
			discharge_switch_gate <= 1'b0; // R13
			narrow_voltage_dc_output <= 1'b0;
		end
		else
		begin
			// Zero-volt: gate fed from the narrow-voltage output, switch in saturation
			narrow_voltage_dc_output <= narrow_voltage_dc_output_nxt; // R8
			charge_switch_gate <= ((phase_nxt == BCS_CC) || (phase_nxt == BCS_CV) ||
				((phase_nxt == BCS_PRE) && !zero_v_w) || narrow_voltage_dc_output_nxt ||
				gate_force_w) && (phase_nxt != BCS_DONE || gate_force_w); // R8 R10 R12
			discharge_switch_gate <= dis_gate_en_w;
		end
	end
endmodule // bcs_sequencer

// ### dv/bcs_buck_model.sv
`timescale 1ns/1ps
// Buck stage, cells and inductor sense as the sequencer sees them
module bcs_buck_model (
	// Bench knobs
	input wire logic [15:0] cell_mv,
	input wire logic taper,
	input wire logic oc,
	// From the sequencer
	input wire logic buck_en,
	// To the sequencer
	output logic [15:0] min_cell_mv,
	output logic [15:0] max_cell_mv,
	output logic [15:0] pack_mv,
	output logic [15:0] meas_ma,
	output logic ind_oc_trip
);
	// Four cells in series, the weakest one 16 mV below the rest
	assign max_cell_mv = cell_mv;
	assign min_cell_mv = cell_mv - 16'h0010;
	assign pack_mv = {cell_mv[13:0], 2'h0};
	// No current while the stage is off, so a stopped buck reads below itap_r just as a taper does
	assign meas_ma = !buck_en ? 16'h0000 : taper ? 16'h0040 : 16'h0700;
	// Inductor overcurrent exists only while switching
	assign ind_oc_trip = oc & buck_en;
endmodule // bcs_buck_model

// ### dv/bcs_sequencer_asserts.sv
`timescale 1ns/1ps
// Bus timing and safety response at the sequencer pins
module bcs_sequencer_asserts (
	// Clock, reset and bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins and drives
	input wire logic safety_fault,
	input wire logic ind_oc_trip,
	input wire logic cycle_kill,
	input wire logic buck_en,
	input wire logic charge_switch_gate,
	input wire logic discharge_switch_gate
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Zero wait state: every setup is answered in the next cycle
	property p_rdy; psel && !penable |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("setup not answered");
	property p_rdy1; pready |=> !pready; endproperty
	a_rdy1: assert property (p_rdy1) else $error("ready longer than one cycle");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	// Read data must not drift between reads
	property p_rdh; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
	a_rdh: assert property (p_rdh) else $error("read data changed");
	property p_rst; $rose(presetn) |-> !buck_en && !charge_switch_gate; endproperty
	a_rst: assert property (p_rst) else $error("drive active after reset");
	// Margin of two cycles beyond the two-flop synchroniser and output register update
	property p_flt;
		safety_fault[*5] |=> !charge_switch_gate && !discharge_switch_gate && !buck_en;
	endproperty
	a_flt: assert property (p_flt) else $error("switches on under fault");
	property p_oc; (ind_oc_trip && buck_en)[*4] |=> cycle_kill; endproperty
	a_oc: assert property (p_oc) else $error("overcurrent not cut");
	property p_nooc; !ind_oc_trip[*4] |=> !cycle_kill; endproperty
	a_nooc: assert property (p_nooc) else $error("cycle cut without trip");
	c_err: cover property (pslverr);
	c_kill: cover property (cycle_kill);
	c_term: cover property ($fell(charge_switch_gate));
endmodule // bcs_sequencer_asserts

bind bcs_sequencer bcs_sequencer_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.prdata, .pready, .pslverr, .safety_fault, .ind_oc_trip, .cycle_kill, .buck_en,
	.charge_switch_gate, .discharge_switch_gate);

// ### dv/test_battery_charge_phase_sequencer.sv
`timescale 1ns/1ps
module test_battery_charge_phase_sequencer
	import bcs_pkg::*;
;
	// Short qualification time keeps the run brief
	localparam longint TERM = 20;
	logic pclk, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic safety_fault = 1'h0, taper = 1'h0, oc = 1'h0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] cell_mv = 16'h0000, min_cell_mv, max_cell_mv, pack_mv, meas_ma;
	logic [15:0] v_target, i_target, i_limit;
	logic pready, pslverr, ind_oc_trip, sense_sel_bottom, cycle_kill, buck_en, ext_pre_sw;
	logic charge_switch_gate, discharge_switch_gate, narrow_voltage_dc_output;
	int n_mismatch = 0, total_checks = 0, cyc = 0;
	bcs_sequencer #(.TERM_CYCLES(TERM)) dut (.*);
	bcs_buck_model u_buck (.*);
	// 10 MHz clock
	initial
	begin
		pclk = 1'h0;
		forever #50 pclk = ~pclk;
	end
	// Hang guard, far above the longest sequence
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 8000)
		begin
			n_mismatch++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		if (n_mismatch == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// One APB transfer; waits an edge first so no signal is set twice in a step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// Poll the phase field with a bounded number of reads
	task automatic wait_phase(input bcs_phase_t p);
		int k;
		k = 0;
		do
		begin
			apb(1'h0, BCS_STAT_OFF, 32'h0);
			k++;
		end
		while (rd[2:0] !== p && k < 60);
		chk(32'(rd[2:0]), 32'(p));
	endtask
	// Reset values, unmapped place, read-only status
	task automatic t_regs();
		apb(1'h0, BCS_CTRL_OFF, 32'h0);
		chk(rd, BCS_CTRL_RST);
		apb(1'h1, 12'h0fc, 32'hffff_ffff);
		chk(32'(err), 32'h1);
		apb(1'h0, 12'h0fc, 32'h0);
		chk(rd, 32'h0);
		apb(1'h1, BCS_STAT_OFF, 32'hffff_ffff);
		apb(1'h0, BCS_STAT_OFF, 32'h0);
		chk(rd, 32'h0);
		chk(32'(discharge_switch_gate), 32'h1);
	endtask
	// Host profile, then both precharge options and zero-volt mode
	task automatic t_pre();
		logic [11:0] a[9] = '{BCS_VCHG_OFF, BCS_ICHG_OFF, BCS_IMAX_OFF, BCS_IPRE_OFF,
			BCS_VPRE_OFF, BCS_VLIM_OFF, BCS_VTLO_OFF, BCS_ITAP_OFF, BCS_TADJ_OFF};
		logic [15:0] v[9] = '{16'h4100, 16'h0800, 16'h0c00, 16'h0100, 16'h0bb8, 16'h1068,
			16'h1004, 16'h0100, 16'h0200};
		for (int i = 0; i < 9; i++)
		begin
			apb(1'h1, a[i], {16'h0000, v[i]});
			apb(1'h0, a[i], 32'h0);
			chk(rd, {16'h0000, v[i]});
		end
		cell_mv <= 16'h0a00;
		apb(1'h1, BCS_CTRL_OFF, 32'h0000_0013);
		wait_phase(BCS_PRE);
		chk(32'(i_target), 32'h0100);
		chk(32'(sense_sel_bottom), 32'h1);
		chk(32'(ext_pre_sw), 32'h1);
		chk(32'(buck_en), 32'h0);
		apb(1'h1, BCS_CTRL_OFF, 32'h0000_0015);
		wait_phase(BCS_PRE);
		chk(32'(ext_pre_sw), 32'h0);
		chk(32'(buck_en), 32'h1);
		chk(32'(narrow_voltage_dc_output), 32'h1);
		chk(32'(charge_switch_gate), 32'h1);
	endtask
	// Derated constant current, request cap, cycle cut-off
	task automatic t_cc();
		cell_mv <= 16'h1010;
		wait_phase(BCS_CC);
		chk(32'(i_target), 32'h0600);
		chk(32'(i_limit), 32'h0800);
		chk(32'(sense_sel_bottom), 32'h0);
		chk(32'(v_target), 32'h4100);
		oc <= 1'h1;
		repeat (5) @(posedge pclk);
		chk(32'(cycle_kill), 32'h1);
		oc <= 1'h0;
		repeat (5) @(posedge pclk);
		chk(32'(cycle_kill), 32'h0);
	endtask
	// Voltage hold, taper dropout restarts the timer, then termination
	task automatic t_term();
		cell_mv <= 16'h1040;
		wait_phase(BCS_CV);
		chk(32'(v_target), 32'h4100);
		chk(32'(sense_sel_bottom), 32'h1);
		taper <= 1'h1;
		repeat (12) @(posedge pclk);
		taper <= 1'h0;
		repeat (2) @(posedge pclk);
		taper <= 1'h1;
		repeat (12) @(posedge pclk);
		apb(1'h0, BCS_STAT_OFF, 32'h0);
		chk(32'(rd[BCS_ST_TERM]), 32'h0);
		// Highest cell at its limit: a higher request must not lift the output
		cell_mv <= 16'h1068;
		apb(1'h1, BCS_VCHG_OFF, 32'h0000_4200);
		repeat (2) @(posedge pclk);
		chk(32'(v_target), 32'h4100);
		wait_phase(BCS_DONE);
		chk(32'(rd[9:8]), 32'h3);
		chk(32'(charge_switch_gate), 32'h0);
		chk(32'(i_limit), 32'h0c00);
		apb(1'h1, BCS_CTRL_OFF, 32'h0000_0019);
		wait_phase(BCS_DONE);
		chk(32'(charge_switch_gate), 32'h1);
		// Restart clears the flags; cell below limit lets the new target through
		cell_mv <= 16'h1040;
		apb(1'h1, BCS_CTRL_OFF, 32'h0000_0031);
		wait_phase(BCS_CC);
		chk(32'(rd[9:8]), 32'h0);
		chk(32'(v_target), 32'h4200);
	endtask
	// Fault overrides the enabled discharge switch and the charge switch in CC
	task automatic t_fault();
		safety_fault <= 1'h1;
		wait_phase(BCS_IDLE);
		chk(32'(rd[BCS_ST_FAULT]), 32'h1);
		chk(32'({charge_switch_gate, discharge_switch_gate, buck_en}), 32'h0);
		safety_fault <= 1'h0;
	endtask
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		t_regs();
		t_pre();
		t_cc();
		t_term();
		t_fault();
		print_verdict();
	end
endmodule // test_battery_charge_phase_sequencer
